//--- rtl/scan_reading_memory.sv
// Time-stamped circular reading memory with latest-per-channel and pop-oldest queries.
// Assumes scan engine, calendar and scan-list lookup run on clk_i; software on classic Wishbone.
// Behaviour
// - Latest query returns that channel's newest N readings, oldest first.
// - Latest query with count omitted (zero) returns only the newest reading.
// - Latest query works during and after a scan; empty memory gives an error.
// - Latest count beyond the channel's held readings gives an error, no data.
// - Latest query on a channel outside the scan list gives an error.
// - Each record carries value, unit, date, time, channel and alarm code 0..3.
// - Stamp is relative time since scan start or calendar time, per setting.
// - Count register reports readings held, zero up to capacity.
// - Capacity is 100000 readings; every stored reading is stamped.
// - Write into a full memory overwrites the oldest and sets overflow bit 12.
// - Overflow clears only on memory clear, not when pops empty the memory.
// - Latest queries keep data; scan start, factory reset and preset discard all.
// - Operation bit 9 sets while count exceeds the threshold, 1 to 100000.
// - Bit 9 stays set until the operation register is read or status cleared.
// - Threshold returns to 1 on factory reset or power-up only.
// - Pop returns the oldest N readings and removes them, during or after scan.
// - Pop of more readings than held gives an error.
// - Consecutive returned records are separated by a comma character.
// - Latest queries are answered at any time, scanning or not.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "reading_memory_regs.svh"

module scan_reading_memory #(
  parameter int unsigned DEPTH = 100000,
  parameter int unsigned CYCLES_PER_TICK = `STAMP_TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rdg_valid_i,
  input wire logic [31:0] rdg_value_i,
  input wire logic [3:0] rdg_unit_i,
  input wire logic [9:0] rdg_channel_i,
  input wire logic [1:0] rdg_alarm_i,
  input wire logic [47:0] cal_time_i,
  input wire logic scan_start_i,
  input wire logic preset_i,
  input wire logic factory_reset_i,
  input wire logic channel_listed_i,
  output logic [9:0] query_channel_o,
  output reading_memory_pkg::query_state_t query_state_o
);
  import reading_memory_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned EW = 97;
  localparam int unsigned TW = $clog2(CYCLES_PER_TICK);

  // Entry layout: {stamp_abs, stamp[47:0], unit, alarm, channel, value}
  logic [EW-1:0] mem [DEPTH];
  logic [EW-1:0] mem_q;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [AW-1:0] ptr_dec(input logic [AW-1:0] p);
    ptr_dec = (p == '0) ? AW'(DEPTH - 1) : p - 1'b1;
  endfunction

  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i && (sel_i == `BYTE_LANES_ALL);
  assign bus_rd = bus_req && !we_i;

  // Configuration and status state
  logic [CW-1:0] thresh, next_thresh;
  logic stamp_abs, next_stamp_abs;
  logic oper_event, next_oper_event;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic [31:0] rel_time, next_rel_time;

  // Memory and query state
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic overflow, next_overflow;
  query_state_t state, next_state;
  query_op_t op, next_op;
  logic [AW-1:0] cursor, next_cursor;
  logic [CW-1:0] scanned, next_scanned;
  logic [CW-1:0] found, next_found;
  logic [CW-1:0] left, next_left;
  logic [CW-1:0] qcount, next_qcount;
  logic [CW-1:0] qn, next_qn;
  logic [9:0] qchan, next_qchan;
  query_err_t ecode, next_ecode;
  logic done, next_done;
  logic [EW-1:0] rec, next_rec;
  logic rec_last, next_rec_last;

  logic mem_clear;
  logic status_clear;
  logic oper_read;
  logic info_read;
  logic launch;
  logic full;
  logic pop_step;
  logic wr_over;
  logic [47:0] stamp_now;
  logic [31:0] next_dat;

  assign full = (count == CW'(DEPTH));
  assign mem_clear = scan_start_i || preset_i || factory_reset_i ||
                     (bus_wr && adr_i == `REG_CTRL && dat_i[`CTRL_CLEAR_MEM]);
  assign status_clear = bus_wr && adr_i == `REG_CTRL && dat_i[`CTRL_CLEAR_STATUS];
  assign oper_read = bus_rd && adr_i == `REG_OPER;
  assign info_read = bus_rd && adr_i == `REG_REC_INFO && state == Q_HOLD;
  assign launch = bus_wr && adr_i == `REG_QCMD && state == Q_IDLE;
  assign pop_step = info_read && op == OP_POP;
  // Pop and overwrite in one cycle free the same slot, so only one advance
  assign wr_over = rdg_valid_i && full && !pop_step;
  assign stamp_now = stamp_abs ? cal_time_i : {16'h0000, rel_time};
  assign query_channel_o = qchan;
  assign query_state_o = state;

  // Time base: millisecond tick, relative time restarts at scan start
  always_comb begin
    next_tick_cnt = tick_cnt + 1'b1;
    next_rel_time = rel_time;
    if (tick_cnt == TW'(CYCLES_PER_TICK - 1)) begin
      next_tick_cnt = '0;
      next_rel_time = rel_time + 32'h00000001;
    end
    if (scan_start_i) begin
      next_tick_cnt = '0;
      next_rel_time = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      rel_time <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      rel_time <= next_rel_time;
    end
  end

  // Configuration, threshold and operation event
  always_comb begin
    next_thresh = thresh;
    next_stamp_abs = stamp_abs;
    next_oper_event = oper_event;
    next_qcount = qcount;
    if (bus_wr && adr_i == `REG_THRESH && dat_i[CW-1:0] != '0 && dat_i[31:CW] == '0 &&
        dat_i[CW-1:0] <= CW'(DEPTH)) begin
      next_thresh = dat_i[CW-1:0];
    end
    if (bus_wr && adr_i == `REG_CFG) begin
      next_stamp_abs = dat_i[`CFG_STAMP_ABS];
    end
    if (bus_wr && adr_i == `REG_QCOUNT) begin
      next_qcount = dat_i[CW-1:0];
    end
    if (factory_reset_i) begin
      next_thresh = CW'(`THRESH_RESET);
    end
    if (oper_read || status_clear) begin
      next_oper_event = 1'b0;
    end
    if (count > thresh) begin
      next_oper_event = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thresh <= CW'(`THRESH_RESET);
      stamp_abs <= 1'b0;
      oper_event <= 1'b0;
      qcount <= '0;
    end else begin
      thresh <= next_thresh;
      stamp_abs <= next_stamp_abs;
      oper_event <= next_oper_event;
      qcount <= next_qcount;
    end
  end

  // Storage array; the read port follows the query cursor
  always_ff @(posedge clk_i) begin
    if (rdg_valid_i && !mem_clear) begin
      mem[wr_ptr] <= {stamp_abs, stamp_now, rdg_unit_i, rdg_alarm_i, rdg_channel_i, rdg_value_i};
    end
    mem_q <= mem[cursor];
  end

  // Pointers, occupancy and the query engine
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overflow = overflow;
    next_state = state;
    next_op = op;
    next_cursor = cursor;
    next_scanned = scanned;
    next_found = found;
    next_left = left;
    next_qn = qn;
    next_qchan = qchan;
    next_ecode = ecode;
    next_done = done;
    next_rec = rec;
    next_rec_last = rec_last;
    if (rdg_valid_i) begin
      next_wr_ptr = ptr_inc(wr_ptr);
      if (wr_over) begin
        next_rd_ptr = ptr_inc(rd_ptr);
        next_overflow = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
    if (pop_step) begin
      next_rd_ptr = ptr_inc(rd_ptr);
      next_count = next_count - 1'b1;
    end
    case (state)
      Q_IDLE: begin
        if (launch) begin
          next_done = 1'b0;
          next_ecode = ERR_NONE;
          next_qchan = dat_i[`QCMD_CHAN_LSB +: 10];
          next_scanned = '0;
          next_found = '0;
          if (dat_i[`QCMD_OP_LSB +: 2] == OP_LATEST) begin
            next_op = OP_LATEST;
            next_qn = (qcount == '0) ? CW'(`DEFAULT_QUERY_COUNT) : qcount;
            next_cursor = ptr_dec(wr_ptr);
            if (count == '0) begin
              next_ecode = ERR_EMPTY;
              next_done = 1'b1;
            end else if (!channel_listed_i) begin
              next_ecode = ERR_CHANNEL;
              next_done = 1'b1;
            end else begin
              next_state = Q_BACK_RD;
            end
          end else if (dat_i[`QCMD_OP_LSB +: 2] == OP_POP) begin
            next_op = OP_POP;
            next_qn = qcount;
            next_left = qcount;
            next_cursor = rd_ptr;
            if (qcount == '0 || qcount > count) begin
              next_ecode = ERR_COUNT;
              next_done = 1'b1;
            end else begin
              next_state = Q_FWD_RD;
            end
          end
        end
      end
      Q_BACK_RD: begin
        next_state = Q_BACK_EVAL;
      end
      Q_BACK_EVAL: begin
        next_scanned = scanned + 1'b1;
        if (mem_q[41:32] == qchan && found + 1'b1 == qn) begin
          next_left = qn;
          next_state = Q_FWD_RD;
        end else if (scanned + 1'b1 >= count) begin
          next_ecode = ERR_COUNT;
          next_done = 1'b1;
          next_state = Q_IDLE;
        end else begin
          if (mem_q[41:32] == qchan) begin
            next_found = found + 1'b1;
          end
          next_cursor = ptr_dec(cursor);
          next_state = Q_BACK_RD;
        end
      end
      Q_FWD_RD: begin
        next_state = Q_FWD_EVAL;
      end
      Q_FWD_EVAL: begin
        if (op == OP_POP || mem_q[41:32] == qchan) begin
          next_rec = mem_q;
          next_rec_last = (left == CW'(1));
          next_state = Q_HOLD;
        end else begin
          next_cursor = ptr_inc(cursor);
          next_state = Q_FWD_RD;
        end
      end
      Q_HOLD: begin
        if (info_read) begin
          next_left = left - 1'b1;
          next_cursor = ptr_inc(cursor);
          if (rec_last) begin
            next_done = 1'b1;
            next_state = Q_IDLE;
          end else begin
            next_state = Q_FWD_RD;
          end
        end
      end
      default: begin
        next_state = Q_IDLE;
      end
    endcase
    // Clearing aborts any query; a write in the same cycle is dropped
    if (mem_clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_overflow = 1'b0;
      next_state = Q_IDLE;
      next_cursor = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      overflow <= 1'b0;
      state <= Q_IDLE;
      op <= OP_NONE;
      cursor <= '0;
      scanned <= '0;
      found <= '0;
      left <= '0;
      qn <= '0;
      qchan <= '0;
      ecode <= ERR_NONE;
      done <= 1'b0;
      rec <= '0;
      rec_last <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overflow <= next_overflow;
      state <= next_state;
      op <= next_op;
      cursor <= next_cursor;
      scanned <= next_scanned;
      found <= next_found;
      left <= next_left;
      qn <= next_qn;
      qchan <= next_qchan;
      ecode <= next_ecode;
      done <= next_done;
      rec <= next_rec;
      rec_last <= next_rec_last;
    end
  end

  // Read data mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    next_dat = 32'h00000000;
    case (adr_i)
      `REG_CFG: next_dat[`CFG_STAMP_ABS] = stamp_abs;
      `REG_COUNT: next_dat[CW-1:0] = count;
      `REG_THRESH: next_dat[CW-1:0] = thresh;
      `REG_QUES: next_dat[`QUES_OVERFLOW] = overflow;
      `REG_OPER: next_dat[`OPER_THRESHOLD] = oper_event;
      `REG_QCOUNT: next_dat[CW-1:0] = qcount;
      `REG_QSTAT: begin
        next_dat[`QSTAT_BUSY] = (state != Q_IDLE);
        next_dat[`QSTAT_REC_VALID] = (state == Q_HOLD);
        next_dat[`QSTAT_ERROR] = (ecode != ERR_NONE);
        next_dat[`QSTAT_ECODE_LSB +: 2] = ecode;
        next_dat[`QSTAT_DONE] = done;
      end
      `REG_REC_VALUE: next_dat = rec[31:0];
      `REG_REC_STAMP_LO: next_dat = rec[79:48];
      `REG_REC_STAMP_HI: next_dat[15:0] = rec[95:80];
      `REG_REC_INFO: begin
        if (state == Q_HOLD) begin
          next_dat[9:0] = rec[41:32];
          next_dat[`INFO_ALARM_LSB +: 2] = rec[43:42];
          next_dat[`INFO_UNIT_LSB +: 4] = rec[47:44];
          next_dat[`INFO_STAMP_ABS] = rec[96];
          next_dat[`INFO_SEP_LSB +: 8] = rec_last ? 8'h00 : `SEPARATOR_CHAR;
        end
      end
      default: next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_rd ? next_dat : 32'h00000000;
    end
  end

  // Checks
  sequence latest_launch_s;
    launch && dat_i[`QCMD_OP_LSB +: 2] == OP_LATEST && !mem_clear;
  endsequence

  sequence pop_launch_s;
    launch && dat_i[`QCMD_OP_LSB +: 2] == OP_POP && !mem_clear;
  endsequence

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> ack_o ##1 !ack_o)
    else $error("Ack not single cycle after request");
  default_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    latest_launch_s and (qcount == '0) |=> qn == CW'(1))
    else $error("Omitted count not taken as one");
  empty_error_a: assert property (@(posedge clk_i) disable iff (rst_i)
    latest_launch_s and (count == '0) |=> state == Q_IDLE && ecode == ERR_EMPTY && done)
    else $error("Empty memory query not refused");
  channel_error_a: assert property (@(posedge clk_i) disable iff (rst_i)
    latest_launch_s and (count != '0) and !channel_listed_i |=> ecode == ERR_CHANNEL && state == Q_IDLE)
    else $error("Unlisted channel not refused");
  count_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count <= CW'(DEPTH))
    else $error("Count above capacity");
  overflow_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rdg_valid_i && full && !pop_step && !mem_clear |=> overflow && full && $changed(rd_ptr))
    else $error("Overwrite did not flag overflow");
  overflow_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !mem_clear |=> overflow)
    else $error("Overflow cleared without memory clear");
  clear_empties_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_clear |=> count == '0 && !overflow && state == Q_IDLE)
    else $error("Clear left readings behind");
  thresh_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count > thresh |=> oper_event)
    else $error("Threshold event not raised");
  event_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    oper_event && !oper_read && !status_clear |=> oper_event)
    else $error("Threshold event dropped early");
  thresh_factory_a: assert property (@(posedge clk_i) disable iff (rst_i)
    factory_reset_i |=> thresh == `THRESH_RESET)
    else $error("Threshold not restored");
  pop_remove_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pop_step && !rdg_valid_i && !mem_clear |=> count == $past(count) - 1'b1)
    else $error("Pop did not remove a reading");
  pop_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pop_launch_s and (qcount > count) |=> ecode == ERR_COUNT && state == Q_IDLE)
    else $error("Oversized pop not refused");
endmodule

//--- rtl/reading_memory_regs.svh
// Register map, field positions, reset values and timing of the reading memory.
// Assumes byte addresses on a 32-bit classic Wishbone bus, one word per register.
`ifndef READING_MEMORY_REGS_SVH
`define READING_MEMORY_REGS_SVH

`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_COUNT 8'h08
`define REG_THRESH 8'h0c
`define REG_QUES 8'h10
`define REG_OPER 8'h14
`define REG_QCOUNT 8'h18
`define REG_QCMD 8'h1c
`define REG_QSTAT 8'h20
`define REG_REC_VALUE 8'h24
`define REG_REC_STAMP_LO 8'h28
`define REG_REC_STAMP_HI 8'h2c
`define REG_REC_INFO 8'h30

`define CTRL_CLEAR_MEM 0
`define CTRL_CLEAR_STATUS 1
`define CFG_STAMP_ABS 0
`define QUES_OVERFLOW 12
`define OPER_THRESHOLD 9
`define QCMD_CHAN_LSB 0
`define QCMD_OP_LSB 16
`define QSTAT_BUSY 0
`define QSTAT_REC_VALID 1
`define QSTAT_ERROR 2
`define QSTAT_ECODE_LSB 4
`define QSTAT_DONE 6
`define INFO_ALARM_LSB 10
`define INFO_UNIT_LSB 12
`define INFO_STAMP_ABS 16
`define INFO_SEP_LSB 24

`define THRESH_RESET 17'h00001
`define DEFAULT_QUERY_COUNT 17'h00001
`define SEPARATOR_CHAR 8'h2c
`define BYTE_LANES_ALL 4'hf

`define CLK_PERIOD_NS 10
`define STAMP_TICK_NS 1000000

`endif

//--- rtl/reading_memory_pkg.sv
// Types shared by the reading memory and its bench.
// Assumes the constants of reading_memory_regs.svh alongside.
package reading_memory_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_LATEST, OP_POP} query_op_t;
  typedef enum logic [1:0] {ERR_NONE, ERR_EMPTY, ERR_CHANNEL, ERR_COUNT} query_err_t;
  typedef enum {Q_IDLE, Q_BACK_RD, Q_BACK_EVAL, Q_FWD_RD, Q_FWD_EVAL, Q_HOLD} query_state_t;
endpackage

//--- verification/reading_source.sv
// Scan engine and scan-list stand-in facing the reading memory.
// Assumes push is entered just after a rising clk_i edge.
`timescale 1ns/10ps
module reading_source #(
  parameter logic [9:0] UNLISTED = 10'h3e7
) (
  input wire logic clk_i,
  input wire logic [31:0] dat_i,
  output logic rdg_valid_o,
  output logic [31:0] rdg_value_o,
  output logic [3:0] rdg_unit_o,
  output logic [9:0] rdg_channel_o,
  output logic [1:0] rdg_alarm_o,
  output logic channel_listed_o
);
  initial begin
    rdg_valid_o = 1'b0;
    rdg_value_o = 32'h0;
    rdg_unit_o = 4'h0;
    rdg_channel_o = 10'h0;
    rdg_alarm_o = 2'h0;
  end
  // Only one channel is left out of the scan list
  assign channel_listed_o = dat_i[9:0] != UNLISTED;
  task automatic push(input logic [31:0] v, input logic [9:0] ch);
    rdg_valid_o <= 1'b1;
    rdg_value_o <= v;
    rdg_unit_o <= 4'h3;
    rdg_channel_o <= ch;
    rdg_alarm_o <= v[1:0];
    @(posedge clk_i);
    // Value, channel and alarm scrambled after the pulse so a late sample cannot pass; unit stays 4'h3
    rdg_valid_o <= 1'b0;
    rdg_value_o <= ~v;
    rdg_channel_o <= ~ch;
    rdg_alarm_o <= ~v[1:0];
    @(posedge clk_i);
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the reading memory.
// Assumes a small DEPTH and tick count so overflow and stamps show quickly.
`timescale 1ns/10ps
`include "reading_memory_regs.svh"
module tb_top;
  import reading_memory_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = `BYTE_LANES_ALL;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic rdg_valid_i, listed;
  logic [31:0] rdg_value_i;
  logic [3:0] rdg_unit_i;
  logic [9:0] rdg_channel_i, query_channel_o;
  logic [1:0] rdg_alarm_i;
  logic [47:0] cal_time_i = 48'h0000_a5a5_0001;
  logic scan_start_i = 1'b0;
  logic preset_i = 1'b0;
  logic factory_reset_i = 1'b0;
  query_state_t query_state_o;
  int bad_count = 0;
  int comparisons = 0;

  always #5 clk_i = ~clk_i;

  scan_reading_memory #(.DEPTH(8), .CYCLES_PER_TICK(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rdg_valid_i(rdg_valid_i), .rdg_value_i(rdg_value_i), .rdg_unit_i(rdg_unit_i),
    .rdg_channel_i(rdg_channel_i), .rdg_alarm_i(rdg_alarm_i), .cal_time_i(cal_time_i),
    .scan_start_i(scan_start_i), .preset_i(preset_i), .factory_reset_i(factory_reset_i),
    .channel_listed_i(listed), .query_channel_o(query_channel_o), .query_state_o(query_state_o));

  reading_source i_src (.clk_i(clk_i), .dat_i(dat_i), .rdg_valid_o(rdg_valid_i), .rdg_value_o(rdg_value_i),
    .rdg_unit_o(rdg_unit_i), .rdg_channel_o(rdg_channel_i), .rdg_alarm_o(rdg_alarm_i),
    .channel_listed_o(listed));

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Held until the edge that sees ack; data taken from that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= `BYTE_LANES_ALL;
    dat_i <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic qry(input logic [1:0] op, input logic [9:0] ch, input logic [16:0] cnt);
    wr(`REG_QCOUNT, {15'h0, cnt});
    wr(`REG_QCMD, {14'h0, op, 6'h0, ch});
  endtask

  task automatic stat_wait(output logic [31:0] s);
    int n;
    for (n = 0; n < 100; n++) begin
      wb(1'b0, `REG_QSTAT, 32'h0, s);
      if (s[1] | s[2]) break;
    end
  endtask

  task automatic rec(input logic [31:0] v, input logic [9:0] ch, input logic [7:0] sep, input logic ab);
    logic [31:0] s;
    stat_wait(s);
    check({31'h0, s[1]}, 32'h1);
    check(query_state_o, Q_HOLD);
    rd_chk(`REG_REC_VALUE, v);
    if (ab) rd_chk(`REG_REC_STAMP_LO, cal_time_i[31:0]);
    rd_chk(`REG_REC_INFO, {sep, 7'h0, ab, 4'h3, v[1:0], ch});
  endtask

  task automatic err(input logic [1:0] code);
    logic [31:0] s;
    stat_wait(s);
    check(s & 32'h36, {26'h0, code, 4'h4});
  endtask

  // One-hot: bit0 preset, bit1 scan start, bit2 factory reset
  task automatic pulse(input logic [2:0] which);
    {factory_reset_i, scan_start_i, preset_i} <= which;
    @(posedge clk_i);
    {factory_reset_i, scan_start_i, preset_i} <= 3'b000;
    @(posedge clk_i);
  endtask

  task automatic t_reset();
    rd_chk(`REG_COUNT, 32'h0);
    rd_chk(`REG_THRESH, 32'h1);
    rd_chk(`REG_QUES, 32'h0);
    rd_chk(8'hfc, 32'h0);
    $display("Test reset values done");
  endtask

  task automatic t_latest();
    i_src.push(32'd11, 10'd5);
    i_src.push(32'd21, 10'd7);
    i_src.push(32'd12, 10'd5);
    i_src.push(32'd22, 10'd7);
    i_src.push(32'd13, 10'd5);
    rd_chk(`REG_COUNT, 32'd5);
    qry(2'd1, 10'd5, 17'd2);
    check({22'h0, query_channel_o}, 32'd5);
    rec(32'd12, 10'd5, `SEPARATOR_CHAR, 1'b0);
    rec(32'd13, 10'd5, 8'h0, 1'b0);
    qry(2'd1, 10'd5, 17'd0);
    rec(32'd13, 10'd5, 8'h0, 1'b0);
    qry(2'd1, 10'd5, 17'd4);
    err(2'd3);
    qry(2'd1, 10'h3e7, 17'd1);
    err(2'd2);
    rd_chk(`REG_COUNT, 32'd5);
    $display("Test latest readings done");
  endtask

  task automatic t_pop();
    qry(2'd2, 10'd0, 17'd2);
    rec(32'd11, 10'd5, `SEPARATOR_CHAR, 1'b0);
    rec(32'd21, 10'd7, 8'h0, 1'b0);
    rd_chk(`REG_COUNT, 32'd3);
    qry(2'd2, 10'd0, 17'd4);
    err(2'd3);
    qry(2'd1, 10'd5, 17'd3);
    err(2'd3);
    $display("Test pop oldest done");
  endtask

  task automatic t_thresh();
    wr(`REG_THRESH, 32'd2);
    rd_chk(`REG_THRESH, 32'd2);
    wr(`REG_THRESH, 32'd0);
    rd_chk(`REG_THRESH, 32'd2);
    rd_chk(`REG_OPER, 32'h200);
    wr(`REG_THRESH, 32'd5);
    rd_chk(`REG_OPER, 32'h200);
    rd_chk(`REG_OPER, 32'h0);
    wr(`REG_THRESH, 32'd2);
    wr(`REG_THRESH, 32'd5);
    wr(`REG_CTRL, 32'h2);
    rd_chk(`REG_OPER, 32'h0);
    $display("Test threshold done");
  endtask

  task automatic t_overflow();
    int i;
    logic [31:0] s;
    wr(`REG_CTRL, 32'h1);
    rd_chk(`REG_COUNT, 32'h0);
    wr(`REG_CFG, 32'h1);
    for (i = 1; i <= 9; i++) i_src.push(i, 10'd1);
    rd_chk(`REG_COUNT, 32'd8);
    rd_chk(`REG_QUES, 32'h1000);
    qry(2'd2, 10'd0, 17'd8);
    for (i = 2; i <= 9; i++) rec(i, 10'd1, (i < 9) ? `SEPARATOR_CHAR : 8'h0, 1'b1);
    rd_chk(`REG_COUNT, 32'h0);
    rd_chk(`REG_QUES, 32'h1000);
    qry(2'd1, 10'd1, 17'd1);
    err(2'd1);
    i_src.push(32'd7, 10'd2);
    pulse(3'b001);
    rd_chk(`REG_QUES, 32'h0);
    rd_chk(`REG_COUNT, 32'h0);
    rd_chk(`REG_THRESH, 32'd5);
    wr(`REG_CFG, 32'h0);
    i_src.push(32'd7, 10'd2);
    pulse(3'b010);
    rd_chk(`REG_COUNT, 32'h0);
    // Sampled 25 cycles after scan start: two 10-cycle ticks, mid-tick margin
    repeat (20) @(posedge clk_i);
    i_src.push(32'd6, 10'd2);
    qry(2'd1, 10'd2, 17'd1);
    stat_wait(s);
    rd_chk(`REG_REC_VALUE, 32'd6);
    rd_chk(`REG_REC_STAMP_LO, 32'd2);
    rd_chk(`REG_REC_STAMP_HI, 32'h0);
    rd_chk(`REG_REC_INFO, {8'h0, 7'h0, 1'b0, 4'h3, 2'd2, 10'd2});
    i_src.push(32'd8, 10'd2);
    pulse(3'b100);
    rd_chk(`REG_COUNT, 32'h0);
    rd_chk(`REG_THRESH, 32'h1);
    $display("Test overflow and clears done");
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_latest();
    t_pop();
    t_thresh();
    t_overflow();
    test_done();
  end

  // Whole run needs several hundred cycles; this leaves ample margin
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
endmodule
